// *** rtl/smc_pkg.sv ***
// Package: constants, offsets and types for the SPI mode extension block
package smc_pkg;

  // Clock and link timing
  localparam int unsigned CLK_PERIOD_NS  = 8;    // System clock period
  localparam int unsigned LINK_PERIOD_NS = 125;  // Serial clock period
  // Half serial period in clocks
  localparam int unsigned HALF_CYCLES =
    (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [31:0] OFF_CTRL     = 32'h0000_0000; // Channel control
  localparam logic [31:0] OFF_TX_DATA  = 32'h0000_0004; // Transmit byte
  localparam logic [31:0] OFF_RX_DATA  = 32'h0000_0008; // Receive byte
  localparam logic [31:0] OFF_INT_STAT = 32'h0000_000c; // Sticky events
  localparam logic [31:0] OFF_INT_CLR  = 32'h0000_0010; // Event clear
  localparam logic [31:0] OFF_INT_EN   = 32'h0000_0014; // Event enable
  // Mode register index, byte address four times it
  localparam logic [31:0] IDX_SPI_MODE_EXT = 32'h0008_a02d;
  localparam logic [31:0] OFF_SPI_MODE_EXT = 32'(IDX_SPI_MODE_EXT * 4);

  // Mode register field positions
  localparam int unsigned B_SEL  = 0; // slave_select_enable
  localparam int unsigned B_FLOW = 1; // flow_control_input_enable
  localparam int unsigned B_SWAP = 2; // master_slave_select
  localparam int unsigned B_FLT  = 4; // mode_fault_flag
  localparam int unsigned B_POL  = 6; // clock_polarity_invert
  localparam int unsigned B_PHA  = 7; // clock_phase_delay
  localparam logic [7:0]  MODE_RST     = 8'h00; // Mode reset value
  localparam logic [7:0]  MODE_CFG_MSK = 8'hc7; // Locked config bits

  // Control register field positions
  localparam int unsigned B_RX_ON    = 0; // rx_on
  localparam int unsigned B_TX_ON    = 1; // tx_on
  localparam int unsigned B_CKS      = 2; // clock_source_sel, 2 bits
  localparam int unsigned B_SPI_MODE = 4; // Simple SPI mode select
  localparam logic [7:0]  CTRL_RST   = 8'h00; // Control reset value
  localparam logic [7:0]  CTRL_MSK   = 8'h1f; // Implemented control bits
  localparam logic [1:0]  CKS_MASTER = 2'h0;  // Internal clock source

  // Event bits
  localparam int unsigned INT_W       = 2; // Number of events
  localparam int unsigned B_INT_DONE  = 0; // Byte transferred
  localparam int unsigned B_INT_FAULT = 1; // Mode fault seen
  localparam int unsigned B_BUSY      = 8; // Busy bit in receive register

  // Transfer length
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial pins, synchronised together
  typedef struct packed {
    logic ss_n; // Shared select / flow control pin
    logic sck;  // Serial clock pin
    logic txd;  // Transmit data pin
    logic rxd;  // Receive data pin
  } smc_pins_s;

  // Transfer engine states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } smc_state_e;

endpackage : smc_pkg

// *** rtl/smc_sync.sv ***
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module smc_sync #(
  parameter int unsigned W = 1  // Number of bits
) (
  input  wire logic         aclk,    // System clock
  input  wire logic         aresetn, // Synchronous reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous inputs
  output logic      [W-1:0] q        // Synchronised outputs
);

  logic [W-1:0] meta_q; // First stage, read only by second stage
  logic [W-1:0] sync_q; // Second stage

  // Two stages, no logic between them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule : smc_sync
`default_nettype wire

// *** rtl/smc_spi_mode.sv ***
// SPI mode extension block with AXI4-Lite registers and shift engine
// Contract
// - Select pin gates transfers only when enabled
// - Config bits writable only while rx/tx off
// - Flow enable: pin is clear-to-send; with neither enable set, request-to-send
// - Select and flow both set act as both clear
// - Master select set swaps transmit and receive data pins
// - Master means clock source 00 and master select 0
// - Select low in SPI master with select enabled sets fault flag
// - Fault flag clears on 0 after read as 1
// - Polarity bit inverts serial clock idle level
// - Phase bit delays clock relative to data
// - Reserved mode bits read as zero
`timescale 1ns/1ps
`default_nettype none
module smc_spi_mode #(
  parameter int unsigned HALF_DIV = smc_pkg::HALF_CYCLES // Half sck period
) (
  input  wire logic        aclk,                // System clock
  input  wire logic        aresetn,             // Sync reset, active low
  input  wire logic [31:0] s_axi_awaddr,        // Write address
  input  wire logic        s_axi_awvalid,       // Write address valid
  output logic             s_axi_awready,       // Write address ready
  input  wire logic [31:0] s_axi_wdata,         // Write data
  input  wire logic [3:0]  s_axi_wstrb,         // Write strobes
  input  wire logic        s_axi_wvalid,        // Write data valid
  output logic             s_axi_wready,        // Write data ready
  output logic [1:0]       s_axi_bresp,         // Write response
  output logic             s_axi_bvalid,        // Write response valid
  input  wire logic        s_axi_bready,        // Write response ready
  input  wire logic [31:0] s_axi_araddr,        // Read address
  input  wire logic        s_axi_arvalid,       // Read address valid
  output logic             s_axi_arready,       // Read address ready
  output logic [31:0]      s_axi_rdata,         // Read data
  output logic [1:0]       s_axi_rresp,         // Read response
  output logic             s_axi_rvalid,        // Read data valid
  input  wire logic        s_axi_rready,        // Read data ready
  input  wire logic        slave_select_pin_in,  // Select / CTS level
  output logic             slave_select_pin_out, // RTS drive level
  output logic             slave_select_pin_oe,  // RTS drive enable
  input  wire logic        transmit_data_pin_in, // Transmit pin level
  output logic             transmit_data_pin_out,// Transmit pin drive
  output logic             transmit_data_pin_oe, // Transmit pin enable
  input  wire logic        receive_data_pin_in,  // Receive pin level
  output logic             receive_data_pin_out, // Receive pin drive
  output logic             receive_data_pin_oe,  // Receive pin enable
  input  wire logic        serial_clock_pin_in,  // Serial clock level
  output logic             serial_clock_pin_out, // Serial clock drive
  output logic             serial_clock_pin_oe,  // Serial clock enable
  output logic             irq                   // Level interrupt
);

  // Synchronised pins
  smc_pkg::smc_pins_s pins_raw;  // Raw pin levels
  smc_pkg::smc_pins_s pins_s;    // Pin levels after two flops

  assign pins_raw.ss_n = slave_select_pin_in;
  assign pins_raw.sck  = serial_clock_pin_in;
  assign pins_raw.txd  = transmit_data_pin_in;
  assign pins_raw.rxd  = receive_data_pin_in;

  smc_sync #(.W($bits(smc_pkg::smc_pins_s))) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pins_raw),
    .q       (pins_s)
  );

  // Register state
  logic [7:0]              mode_q;     // spi_mode_extension
  logic [7:0]              ctrl_q;     // serial_ctrl_reg
  logic [7:0]              rx_data_q;  // Last received byte
  logic [smc_pkg::INT_W-1:0] stat_q;   // Sticky events
  logic [smc_pkg::INT_W-1:0] en_q;     // Event enables
  logic                    flt_rd_q;   // Fault flag read as 1

  // Engine state
  smc_pkg::smc_state_e state_q;  // Idle or running
  logic [7:0]          sh_q;     // Shift register
  logic [3:0]          cnt_q;    // Bits sampled
  logic                bit_q;    // Sampled bit awaiting shift
  logic                first_q;  // No leading edge yet
  logic [7:0]          div_q;    // Master clock divider
  logic                sck_q;    // Master serial clock
  logic                sck_prev_q; // Previous sampled pin clock

  // Pin output flops
  logic txd_out_q, txd_oe_q, rxd_out_q, rxd_oe_q;
  logic sck_oe_q, ss_out_q, ss_oe_q, irq_q;

  // AXI slave state
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_held_q, w_held_q;  // Address / data captured
  logic [31:0] awaddr_q;             // Captured write address
  logic [31:0] wdata_q;              // Captured write data
  logic        wlane0_q;             // Byte lane 0 strobe
  logic [1:0]  bresp_q, rresp_q;     // Responses
  logic [31:0] rdata_q;              // Read data

  // Mode and control field decode
  wire sel_en   = mode_q[smc_pkg::B_SEL];
  wire flow_en  = mode_q[smc_pkg::B_FLOW];
  wire swap     = mode_q[smc_pkg::B_SWAP];
  wire pol      = mode_q[smc_pkg::B_POL];
  wire pha      = mode_q[smc_pkg::B_PHA];
  wire rx_on    = ctrl_q[smc_pkg::B_RX_ON];
  wire tx_on    = ctrl_q[smc_pkg::B_TX_ON];
  wire spi_mode = ctrl_q[smc_pkg::B_SPI_MODE];
  wire [1:0] cks = ctrl_q[smc_pkg::B_CKS +: 2];

  // Both enables together count as neither
  wire both_en = sel_en & flow_en;
  wire sel_eff = sel_en & ~both_en;
  wire flw_eff = flow_en & ~both_en;

  // Master when internal clock and master select clear
  wire master = (cks == smc_pkg::CKS_MASTER) & ~swap;
  wire ss_low = ~pins_s.ss_n;
  wire running = (state_q == smc_pkg::ST_RUN);
  wire chan_on = rx_on | tx_on;

  // Slave deselected: select enabled in SPI slave and pin high
  wire slave_sel = ~(spi_mode & sel_eff & ~master) | ss_low;
  // Clear-to-send gates transfers when flow input enabled
  wire cts_ok = ~flw_eff | ss_low;
  // Mode fault: select low during SPI master with select enabled
  wire fault_ev = spi_mode & sel_eff & master & ss_low;

  // Receive data from the pin chosen by master select
  wire din = swap ? pins_s.txd : pins_s.rxd;

  // Master clock edges
  wire div_end = (div_q == 8'(HALF_DIV - 1));
  wire m_tog   = running & master & cts_ok & div_end;
  wire m_lead  = m_tog & (sck_q == pol);
  wire m_trail = m_tog & (sck_q != pol);
  // Slave clock edges, only while selected
  wire s_edge  = running & ~master & slave_sel &
                 (pins_s.sck != sck_prev_q);
  wire s_lead  = s_edge & (pins_s.sck != pol);
  wire s_trail = s_edge & (pins_s.sck == pol);
  wire lead_ev  = master ? m_lead : s_lead;
  wire trail_ev = master ? m_trail : s_trail;

  // Phase picks which edge samples and which shifts
  wire sample_ev = pha ? trail_ev : lead_ev;
  wire shift_ev  = pha ? lead_ev : trail_ev;
  wire shift_do  = shift_ev & ~(pha & first_q);
  wire done_ev   = pha ?
                   (sample_ev & (cnt_q == 4'(smc_pkg::BITS_PER_BYTE - 1))) :
                   (shift_ev & (cnt_q == smc_pkg::BITS_PER_BYTE));
  wire last_bit  = pha ? din : bit_q;
  wire abort     = running & (~chan_on | (master & fault_ev));

  // AXI handshakes
  wire aw_hs  = s_axi_awvalid & awready_q;
  wire w_hs   = s_axi_wvalid & wready_q;
  wire b_hs   = bvalid_q & s_axi_bready;
  wire ar_hs  = s_axi_arvalid & arready_q;
  wire r_hs   = rvalid_q & s_axi_rready;
  wire wr_do  = aw_held_q & w_held_q & ~bvalid_q;
  wire wr_en  = wr_do & wlane0_q;

  // Write address decode
  wire wa_ctrl = (awaddr_q == smc_pkg::OFF_CTRL);
  wire wa_tx   = (awaddr_q == smc_pkg::OFF_TX_DATA);
  wire wa_clr  = (awaddr_q == smc_pkg::OFF_INT_CLR);
  wire wa_en   = (awaddr_q == smc_pkg::OFF_INT_EN);
  wire wa_mode = (awaddr_q == smc_pkg::OFF_SPI_MODE_EXT);
  wire wa_hit  = wa_ctrl | wa_tx | wa_clr | wa_en | wa_mode |
                 (awaddr_q == smc_pkg::OFF_RX_DATA) |
                 (awaddr_q == smc_pkg::OFF_INT_STAT);

  // Read address decode
  wire ra_mode = (s_axi_araddr == smc_pkg::OFF_SPI_MODE_EXT);
  wire [31:0] rd_mux =
    (s_axi_araddr == smc_pkg::OFF_CTRL) ? {24'h0, ctrl_q} :
    (s_axi_araddr == smc_pkg::OFF_RX_DATA) ? {23'h0, running, rx_data_q} :
    (s_axi_araddr == smc_pkg::OFF_INT_STAT) ? {30'h0, stat_q} :
    (s_axi_araddr == smc_pkg::OFF_INT_EN) ? {30'h0, en_q} :
    ra_mode ? {24'h0, mode_q} : 32'h0;
  wire ra_hit = ra_mode |
    (s_axi_araddr == smc_pkg::OFF_CTRL) |
    (s_axi_araddr == smc_pkg::OFF_TX_DATA) |
    (s_axi_araddr == smc_pkg::OFF_RX_DATA) |
    (s_axi_araddr == smc_pkg::OFF_INT_STAT) |
    (s_axi_araddr == smc_pkg::OFF_INT_CLR) |
    (s_axi_araddr == smc_pkg::OFF_INT_EN);

  // Engine start on a transmit write
  wire start_ev = wr_en & wa_tx & ~running & chan_on & cts_ok &
                  ~(master & fault_ev);
  // Config bits locked while rx or tx is on
  wire cfg_open = ~rx_on & ~tx_on;
  wire flt_clr  = wr_en & wa_mode & ~wdata_q[smc_pkg::B_FLT] &
                  flt_rd_q;
  wire [7:0] mode_cfg_d = cfg_open ?
    (wdata_q[7:0] & smc_pkg::MODE_CFG_MSK) :
    (mode_q & smc_pkg::MODE_CFG_MSK);
  wire flt_d = (spi_mode & fault_ev) |
               (mode_q[smc_pkg::B_FLT] & ~flt_clr);
  wire [smc_pkg::INT_W-1:0] ev_d = {fault_ev, done_ev & running};
  wire [smc_pkg::INT_W-1:0] clr_d =
    (wr_en & wa_clr) ? wdata_q[smc_pkg::INT_W-1:0] : '0;

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 32'h0;
      wdata_q   <= 32'h0;
      wlane0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= smc_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin           // Take address
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
        awready_q <= 1'b0;
      end else if (~aw_held_q & ~bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (w_hs) begin            // Take data
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wlane0_q <= s_axi_wstrb[0];
        wready_q <= 1'b0;
      end else if (~w_held_q & ~bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (wr_do) begin           // Both present: answer
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wa_hit ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= smc_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= ra_hit ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
    end else if (r_hs) begin
      rvalid_q <= 1'b0;
    end else if (~rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q     <= smc_pkg::MODE_RST;
      ctrl_q     <= smc_pkg::CTRL_RST;
      en_q       <= '0;
      stat_q     <= '0;
      flt_rd_q   <= 1'b0;
    end else begin
      if (wr_en & wa_ctrl) begin
        ctrl_q <= wdata_q[7:0] & smc_pkg::CTRL_MSK;
      end
      if (wr_en & wa_en) begin
        en_q <= wdata_q[smc_pkg::INT_W-1:0];
      end
      // Sticky events: a new event wins over a clear
      stat_q <= ev_d | (stat_q & ~clr_d);
      // Reserved bits never set
      mode_q <= (wr_en & wa_mode) ? mode_cfg_d :
                (mode_q & smc_pkg::MODE_CFG_MSK);
      mode_q[smc_pkg::B_FLT] <= flt_d;
      // Remember a read that saw the flag set
      if (flt_clr | ~mode_q[smc_pkg::B_FLT]) begin
        flt_rd_q <= 1'b0;
      end else if (ar_hs & ra_mode) begin
        flt_rd_q <= 1'b1;
      end
    end
  end

  // Transfer state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= smc_pkg::ST_IDLE;
    end else begin
      case (state_q)
        smc_pkg::ST_IDLE: begin
          if (start_ev) state_q <= smc_pkg::ST_RUN;
        end
        smc_pkg::ST_RUN: begin
          if (abort | done_ev) state_q <= smc_pkg::ST_IDLE;
        end
        default: state_q <= smc_pkg::ST_IDLE;
      endcase
    end
  end

  // Shift engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q      <= 8'h0;
      cnt_q     <= 4'h0;
      bit_q     <= 1'b0;
      first_q   <= 1'b1;
      rx_data_q <= 8'h0;
    end else if (start_ev) begin
      sh_q    <= wdata_q[7:0];
      cnt_q   <= 4'h0;
      first_q <= 1'b1;
    end else if (running & ~master & ~slave_sel) begin
      cnt_q   <= 4'h0;
      first_q <= 1'b1;
    end else begin
      if (lead_ev) first_q <= 1'b0;
      if (sample_ev) begin
        bit_q <= din;
        cnt_q <= cnt_q + 4'h1;
      end
      if (shift_do) sh_q <= {sh_q[6:0], bit_q};
      if (done_ev) rx_data_q <= {sh_q[6:0], last_bit};
    end
  end

  // Master clock generator and pin clock history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q      <= 8'h0;
      sck_q      <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= pins_s.sck;
      if (~running) begin
        div_q <= 8'h0;
        sck_q <= pol;
      end else if (master & cts_ok) begin
        div_q <= div_end ? 8'h0 : div_q + 8'h1;
        if (div_end) sck_q <= ~sck_q;
      end
    end
  end

  // Pin drivers, registered
  wire data_drv = tx_on & (master | slave_sel);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_out_q <= 1'b1;
      txd_oe_q  <= 1'b0;
      rxd_out_q <= 1'b1;
      rxd_oe_q  <= 1'b0;
      sck_oe_q  <= 1'b0;
      ss_out_q  <= 1'b1;
      ss_oe_q   <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      txd_out_q <= sh_q[7];
      txd_oe_q  <= data_drv & ~swap;
      rxd_out_q <= sh_q[7];
      rxd_oe_q  <= data_drv & swap;
      sck_oe_q  <= master & chan_on;
      // Request-to-send low while ready to receive
      ss_out_q  <= ~(rx_on & ~running);
      ss_oe_q   <= ~sel_eff & ~flw_eff;
      irq_q     <= |(stat_q & en_q);
    end
  end

  // Outputs straight from flops
  assign s_axi_awready         = awready_q;
  assign s_axi_wready          = wready_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = rresp_q;
  assign transmit_data_pin_out = txd_out_q;
  assign transmit_data_pin_oe  = txd_oe_q;
  assign receive_data_pin_out  = rxd_out_q;
  assign receive_data_pin_oe   = rxd_oe_q;
  assign serial_clock_pin_out  = sck_q;
  assign serial_clock_pin_oe   = sck_oe_q;
  assign slave_select_pin_out  = ss_out_q;
  assign slave_select_pin_oe   = ss_oe_q;
  assign irq                   = irq_q;

endmodule : smc_spi_mode
`default_nettype wire

// *** sim/smc_spi_mode_chk.sv ***
// Checker for the SPI mode block
`timescale 1ns/1ps
`default_nettype none
module smc_spi_mode_chk #(
  parameter int unsigned HALF_DIV = 7  // Half serial clock period
) (
  input wire logic        aclk, aresetn, // Clock, reset
  input wire logic        s_axi_awvalid, s_axi_awready, // Write address
  input wire logic        s_axi_wvalid, s_axi_wready, // Write data
  input wire logic        s_axi_bvalid, s_axi_bready, // Write answer
  input wire logic        s_axi_arvalid, s_axi_arready, // Read address
  input wire logic        s_axi_rvalid, s_axi_rready, // Read answer
  input wire logic [31:0] s_axi_rdata, // Read word
  input wire logic        transmit_data_pin_oe, // Transmit enable
  input wire logic        receive_data_pin_oe, // Receive enable
  input wire logic        serial_clock_pin_oe, // Clock enable
  input wire logic        serial_clock_pin_out, // Clock level
  input wire logic        irq // Interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_rd_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_wr_rearm: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
    else $error("write ready lost");
  chk_rd_rearm: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid ##1 s_axi_arready)
    else $error("read ready lost");
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
    else $error("rdata high bits set");
  chk_pin_swap: assert property (
    !(transmit_data_pin_oe && receive_data_pin_oe))
    else $error("both data pins driven");
  // Clock level holds at least six cycles after a change
  chk_sck_half: assert property (
    serial_clock_pin_oe && $changed(serial_clock_pin_out) |=>
    $stable(serial_clock_pin_out) [*5])
    else $error("sck half period short");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !serial_clock_pin_oe)
    else $error("outputs live in reset");
endmodule : smc_spi_mode_chk
bind smc_spi_mode smc_spi_mode_chk #(.HALF_DIV(HALF_DIV)) i_chk (.*);
`default_nettype wire

// *** sim/smc_peer.sv ***
// SPI slave peer model
`timescale 1ns/1ps
`default_nettype none
module smc_peer (
  input  wire logic       aclk,    // System clock
  input  wire logic       sck,     // Serial clock wire
  input  wire logic       mosi,    // Data from master
  input  wire logic       cpol,    // Idle clock level
  input  wire logic       cpha,    // Delayed clock phase
  input  wire logic       load,    // Preload reply byte
  input  wire logic [7:0] tx_byte, // Reply byte
  output logic            miso,    // Data to master
  output logic      [7:0] rx_byte  // Byte taken from master
);
  logic       sck_p; // Clock level one cycle ago
  logic [7:0] sh;    // Reply shifter
  logic       lead;  // Clock off idle
  assign lead = (sck != cpol);
  initial miso = 1'b1;
  // Sample on one edge, change on the other
  always @(posedge aclk) begin
    sck_p <= sck;
    if (load) begin
      sh   <= cpha ? tx_byte : {tx_byte[6:0], 1'b0};
      miso <= cpha ^ tx_byte[7]; // First bit early unless delayed
    end else if (sck != sck_p) begin
      if (lead ^ cpha) rx_byte <= {rx_byte[6:0], mosi};
      else begin
        miso <= sh[7];
        sh   <= {sh[6:0], ~sh[0]}; // Filler keeps changing
      end
    end
  end
endmodule : smc_peer
`default_nettype wire

// *** sim/serial_spi_mode_control_test.sv ***
// Bench for the SPI mode block
`timescale 1ns/1ps
`default_nettype none
module serial_spi_mode_control_test;
  localparam logic [31:0] A_MODE = smc_pkg::OFF_SPI_MODE_EXT; // Mode reg
  localparam logic [31:0] A_CTRL = smc_pkg::OFF_CTRL;         // Control
  logic        aclk = 1'b0, aresetn = 1'b0; // Clock, reset
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf; // Whole word writes
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq, transmit_data_pin_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr; // Responses
  logic [31:0] s_axi_rdata, rd; // Read words
  logic        slave_select_pin_in, slave_select_pin_out, slave_select_pin_oe;
  logic        transmit_data_pin_in, transmit_data_pin_out;
  logic        receive_data_pin_in, receive_data_pin_out, receive_data_pin_oe;
  logic        serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe;
  logic        ss_level = 1'b1, load = 1'b0, miso; // Peer side
  logic [7:0]  cfg = '0, tx_byte = '0, rx_byte, c, b;
  logic [7:0]  pm [3] = '{8'h00, 8'h02, 8'h03}; // Shared pin configs
  int          errors = 0, check_count = 0;
  // Released transmit and clock lines show the inverse of their last drive
  assign slave_select_pin_in =
    slave_select_pin_oe ? slave_select_pin_out : ss_level;
  assign transmit_data_pin_in =
    transmit_data_pin_oe ? transmit_data_pin_out : ~transmit_data_pin_out;
  assign receive_data_pin_in = receive_data_pin_oe ? receive_data_pin_out : miso;
  assign serial_clock_pin_in =
    serial_clock_pin_oe ? serial_clock_pin_out : ~serial_clock_pin_out;
  smc_spi_mode i_dut (.*);
  smc_peer i_peer (.aclk(aclk), .sck(serial_clock_pin_in),
    .mosi(transmit_data_pin_in), .cpol(cfg[6]), .cpha(cfg[7]), .load(load),
    .tx_byte(tx_byte), .miso(miso), .rx_byte(rx_byte));
  always #4 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic hang;
    errors++;
    $display("Error wait expected answer seen timeout");
    tally_and_finish();
  endtask : hang
  // Write one byte
  task automatic axw(input logic [31:0] a, input logic [7:0] d);
    int t;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (t == 50) hang();
  endtask : axw
  task automatic axr(input logic [31:0] a);
    int t;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (t == 50) hang();
  endtask : axr
  task automatic rchk(input string nm, input logic [31:0] a, exp);
    axr(a);
    chk(nm, rd, exp);
  endtask : rchk
  task automatic wirq(input logic lvl);
    int t;
    for (t = 0; t < 400; t++) begin
      @(posedge aclk);
      if (irq === lvl) break;
    end
    if (t == 400) hang();
  endtask : wirq
  // Mode read-back keeps config bits
  function automatic logic [31:0] exp_mode(input logic [7:0] v);
    return {24'h0, v & smc_pkg::MODE_CFG_MSK};
  endfunction : exp_mode
  initial begin
    void'($urandom(73676));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk("mode reset", A_MODE, 32'h0);
    axr(32'h100);
    chk("unmapped rd", 32'(rr), 32'(smc_pkg::RESP_SLVERR));
    axw(A_CTRL, 8'h07);
    repeat (3) @(posedge aclk);
    chk("ext clock oe", 32'(serial_clock_pin_oe), 32'h0);
    foreach (pm[i]) begin
      axw(A_MODE, pm[i]);
      axw(A_CTRL, 8'h01);
      repeat (3) @(posedge aclk);
      chk("rts", 32'(slave_select_pin_oe), 32'(pm[i] != 8'h02));
      axw(A_CTRL, 8'h00);
    end
    for (int m = 0; m < 4; m++) begin
      c = (8'(m) << 6) | (8'h28 & 8'($urandom));
      cfg <= c;
      axw(A_MODE, c);
      rchk("mode cfg", A_MODE, exp_mode(c));
      axw(A_CTRL, 8'h13);
      axw(A_MODE, c ^ 8'hc7);
      chk("wr resp", 32'(rr), 32'(smc_pkg::RESP_OKAY));
      rchk("mode locked", A_MODE, exp_mode(c));
      chk("sck idle", 32'(serial_clock_pin_out), 32'(c[6]));
      b = 8'($urandom);
      tx_byte <= 8'($urandom);
      load <= 1'b1;
      axw(smc_pkg::OFF_INT_EN, 8'h01);
      load <= 1'b0;
      axw(smc_pkg::OFF_TX_DATA, b);
      wirq(1'b1);
      chk("peer rx", 32'(rx_byte), 32'(b));
      axr(smc_pkg::OFF_RX_DATA);
      chk("rx byte", 32'(rd[7:0]), 32'(tx_byte));
      axw(smc_pkg::OFF_INT_CLR, 8'h01);
      wirq(1'b0);
      axw(A_CTRL, 8'h00);
    end
    axw(A_MODE, 8'h01);
    axw(A_CTRL, 8'h13);
    ss_level <= 1'b0;
    repeat (8) @(posedge aclk);
    ss_level <= 1'b1;
    repeat (4) @(posedge aclk);
    axw(A_MODE, 8'h01);
    rchk("fault unread", A_MODE, 32'h11);
    chk("irq masked", 32'(irq), 32'h0);
    axw(A_MODE, 8'h11);
    rchk("fault w1", A_MODE, 32'h11);
    axw(A_MODE, 8'h01);
    rchk("fault clr", A_MODE, 32'h01);
    rchk("fault stat", smc_pkg::OFF_INT_STAT, 32'h2);
    axw(smc_pkg::OFF_INT_EN, 8'h03);
    wirq(1'b1);
    axw(smc_pkg::OFF_INT_CLR, 8'h02);
    wirq(1'b0);
    tally_and_finish();
  end
endmodule : serial_spi_mode_control_test
`default_nettype wire
